// ### hdl/photon_counter_defs.svh
// constants for the photon counter measurement control
// assumes a 125 MHz mclk; every figure here is used by photon_counter_control
`ifndef PHOTON_COUNTER_DEFS_SVH
`define PHOTON_COUNTER_DEFS_SVH
`define CLK_PERIOD_NS 8
`define TIME_STEP_NS 1000
`define CYC_PER_STEP ((`TIME_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_IDLE 3'h0
`define MODE_MANUAL 3'h1
`define MODE_FREE_RUN 3'h2
`define MODE_TRIG_TIMED 3'h3
`define MODE_TRIG_UNTIMED 3'h4
`define MODE_EXT_GATE 3'h5
`define MODE_MAX 32'h0000_0005
`define TIME_MIN 32'h0000_0001
`define TIME_MAX 32'h7fff_ffff
`define ARRAY_MIN 32'h0000_0001
`define ARRAY_MAX 32'h0000_2710
`define DFU_MAX 32'h0000_0002
`define BIN_LEN_RST 32'h0000_0001
`define PAUSE_RST 32'h0000_0001
`define ARRAY_LEN_RST 14'h0001
`define FAN_RST 1'b1
`define LED_RST 1'b1
`define ST_RUN 0
`define ST_GATE 1
`define ST_WAIT 2
`define ST_OVF 3
`define ST_OVL 4
`define ST_TEMP 5
`define ST_SAT 6
`define ST_ACC 10
`endif

// ### hdl/photon_counter_pkg.sv
// types shared by the photon counter measurement control
// assumes nothing of its surroundings
package photon_counter_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ARMED = 4'b0010,
		S_COUNT = 4'b0100,
		S_PAUSE = 4'b1000
	} meas_state_type;
	typedef enum logic [3:0] {
		SEL_MODE = 4'h0,
		SEL_GATING = 4'h1,
		SEL_BIN_LEN = 4'h2,
		SEL_PAUSE = 4'h3,
		SEL_EDGE = 4'h4,
		SEL_ARR_LEN = 4'h5,
		SEL_ARR_STATE = 4'h6,
		SEL_STATUS = 4'h7,
		SEL_FAN = 4'h8,
		SEL_LED = 4'h9,
		SEL_DFU = 4'ha,
		SEL_SAT_VOLT = 4'hb,
		SEL_START = 4'hc,
		SEL_STOP = 4'hd,
		SEL_CLEAR = 4'he,
		SEL_INDEX = 4'hf
	} cmd_sel_type;
endpackage : photon_counter_pkg

// ### hdl/photon_counter_control.sv
// photon counter measurement control: command port, bin timing, status word, result fifo
// assumes all inputs synchronous to mclk; commands arrive already parsed, one per cycle
// Overview of operation
// - mode code 0..5 selects idle, manual, free-run, triggered timed, untimed, gating
// - gating select 0 keeps diode biased always, 1 biases it only while a bin is counting
// - with gated bias, bias turns on on the same edge a bin starts
// - pause between free-running bins, same range and step, readable back
// - trigger edge select: 0 falling, 1 rising, readable back
// - bins per array 1 to 10000, readable back
// - array state 0 continuous, 1 array of programmed bin count, readable back
// - result holds 31-bit photon count with overflow flag in bit 31
// - result carries status word and index from 1 up; index 0 means none
// - status bits 0..3: running, gate active, waiting trigger, overflow
// - status bit 4 overload of result path, bit 5 cooler overtemperature
// - status bits 6 and 7 give the two-bit saturation level, 3 is alert
// - bits 10..14 are sticky flags for overflow, result dropped by overload, temperature, saturation
// - clear command zeroes the sticky bits, live bits untouched
// - start counts at once in manual and free-run modes, arms modes 3 to 5, sets running; refused in idle
// - stop ends counting in manual mode, disarms others, clears running
// - fan on/off control, 1 on, readable back
// - led on after reset, off at start, on at stop, writable and readable
// - firmware-update state 0,1,2; writing 1 or 2 requests usb re-enumeration
// - saturation voltage, 0.0 to 3.3 V, reported on request
// - triggered timed mode ignores trigger edges while a bin is running
// - untimed mode: each trigger edge ends the bin and starts the next
// - gating mode counts only while the gate input is high
`timescale 1ns/100ps
`include "photon_counter_defs.svh"

module result_fifo #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] fill_r, fill_nxt;
	logic push, pop;

	assign in_ready = fill_r != FULL;
	assign out_valid = fill_r != '0;
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		fill_nxt = fill_r;
		if (push) begin
			wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
		end
		if (pop) begin
			rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
		end
		if (push && !pop) begin
			fill_nxt = fill_r + 1'b1;
		end else if (pop && !push) begin
			fill_nxt = fill_r - 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_r <= '0;
			rd_r <= '0;
			fill_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			fill_r <= fill_nxt;
		end
	end

	// storage needs no reset; out_data is only meaningful with out_valid
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
endmodule : result_fifo

module photon_counter_control
	import photon_counter_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire cmd_sel_type cmd_sel,
	input wire logic [31:0] cmd_data,
	output logic answer_valid,
	output logic answer_error,
	output logic [31:0] answer_data,
	input wire logic photon_in,
	input wire logic trigger_in,
	input wire logic gate_in,
	input wire logic overtemp_in,
	input wire logic [1:0] saturation_in,
	input wire logic [11:0] sat_voltage_mv,
	output logic result_valid,
	input wire logic result_ready,
	output logic [31:0] result_count,
	output logic [15:0] result_status,
	output logic [31:0] result_index,
	output logic [15:0] status_word,
	output logic bias_enable,
	output logic fan_on,
	output logic led_on,
	output logic [1:0] dfu_state,
	output logic usb_reenumerate
);
	localparam int PW = $clog2(`CYC_PER_STEP);
	localparam logic [PW-1:0] PRESC_LAST = PW'(`CYC_PER_STEP - 1);

	meas_state_type state_r, state_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic gating_r, gating_nxt, edge_r, edge_nxt, arr_state_r, arr_state_nxt;
	logic [31:0] bin_len_r, bin_len_nxt, pause_r, pause_nxt;
	logic [13:0] arr_len_r, arr_len_nxt, bins_r, bins_nxt;
	logic fan_r, fan_nxt, led_r, led_nxt, reenum_r, reenum_nxt;
	logic [1:0] dfu_r, dfu_nxt;
	logic running_r, running_nxt, bias_r, bias_nxt;
	logic [PW-1:0] presc_r, presc_nxt;
	logic [31:0] remain_r, remain_nxt, index_r, index_nxt;
	logic [30:0] count_r, count_nxt;
	logic ovf_r, ovf_nxt, trig_prev_r, photon_prev_r;
	logic [4:0] sticky_r, sticky_nxt;
	logic [15:0] status_r, status_nxt;
	logic ans_valid_r, ans_valid_nxt, ans_err_r, ans_err_nxt;
	logic [31:0] ans_data_r, ans_data_nxt;
	logic photon_rise, trig_edge, step_tick, timer_done;
	logic start_req, stop_req, clear_req, emit, bin_start, fifo_ready;
	logic [79:0] fifo_out;

	assign photon_rise = photon_in && !photon_prev_r;
	assign trig_edge = edge_r ? (trigger_in && !trig_prev_r) : (!trigger_in && trig_prev_r);
	assign step_tick = presc_r == PRESC_LAST;
	assign timer_done = step_tick && (remain_r == 32'h0000_0001);

	always_comb begin
		mode_nxt = mode_r;
		gating_nxt = gating_r;
		bin_len_nxt = bin_len_r;
		pause_nxt = pause_r;
		edge_nxt = edge_r;
		arr_len_nxt = arr_len_r;
		arr_state_nxt = arr_state_r;
		fan_nxt = fan_r;
		led_nxt = led_r;
		dfu_nxt = dfu_r;
		reenum_nxt = 1'b0;
		ans_valid_nxt = cmd_valid;
		ans_err_nxt = 1'b0;
		ans_data_nxt = '0;
		start_req = 1'b0;
		stop_req = 1'b0;
		clear_req = 1'b0;
		if (cmd_valid && cmd_write) begin
			// rejected values leave the setting as it was
			unique case (cmd_sel)
				SEL_MODE: if (cmd_data <= `MODE_MAX) mode_nxt = cmd_data[2:0];
					else ans_err_nxt = 1'b1;
				SEL_GATING: if (cmd_data[31:1] == '0) gating_nxt = cmd_data[0];
					else ans_err_nxt = 1'b1;
				SEL_BIN_LEN: if (cmd_data >= `TIME_MIN && cmd_data <= `TIME_MAX) bin_len_nxt = cmd_data;
					else ans_err_nxt = 1'b1;
				SEL_PAUSE: if (cmd_data >= `TIME_MIN && cmd_data <= `TIME_MAX) pause_nxt = cmd_data;
					else ans_err_nxt = 1'b1;
				SEL_EDGE: if (cmd_data[31:1] == '0) edge_nxt = cmd_data[0];
					else ans_err_nxt = 1'b1;
				SEL_ARR_LEN: if (cmd_data >= `ARRAY_MIN && cmd_data <= `ARRAY_MAX) arr_len_nxt = cmd_data[13:0];
					else ans_err_nxt = 1'b1;
				SEL_ARR_STATE: if (cmd_data[31:1] == '0) arr_state_nxt = cmd_data[0];
					else ans_err_nxt = 1'b1;
				SEL_FAN: if (cmd_data[31:1] == '0) fan_nxt = cmd_data[0];
					else ans_err_nxt = 1'b1;
				SEL_LED: if (cmd_data[31:1] == '0) led_nxt = cmd_data[0];
					else ans_err_nxt = 1'b1;
				SEL_DFU: if (cmd_data <= `DFU_MAX) begin
					dfu_nxt = cmd_data[1:0];
					reenum_nxt = cmd_data[1:0] != 2'h0;
				end else ans_err_nxt = 1'b1;
				SEL_START: if (mode_r != `MODE_IDLE) start_req = 1'b1;
					else ans_err_nxt = 1'b1;
				SEL_STOP: stop_req = 1'b1;
				SEL_CLEAR: clear_req = 1'b1;
				default: ans_err_nxt = 1'b1;
			endcase
		end else if (cmd_valid) begin
			unique case (cmd_sel)
				SEL_MODE: ans_data_nxt = {29'h0, mode_r};
				SEL_GATING: ans_data_nxt = {31'h0, gating_r};
				SEL_BIN_LEN: ans_data_nxt = bin_len_r;
				SEL_PAUSE: ans_data_nxt = pause_r;
				SEL_EDGE: ans_data_nxt = {31'h0, edge_r};
				SEL_ARR_LEN: ans_data_nxt = {18'h0, arr_len_r};
				SEL_ARR_STATE: ans_data_nxt = {31'h0, arr_state_r};
				SEL_STATUS: ans_data_nxt = {16'h0, status_r};
				SEL_FAN: ans_data_nxt = {31'h0, fan_r};
				SEL_LED: ans_data_nxt = {31'h0, led_r};
				SEL_DFU: ans_data_nxt = {30'h0, dfu_r};
				SEL_SAT_VOLT: ans_data_nxt = {20'h0, sat_voltage_mv};
				SEL_INDEX: ans_data_nxt = index_r;
				default: ans_err_nxt = 1'b1;
			endcase
		end

		state_nxt = state_r;
		running_nxt = running_r;
		presc_nxt = step_tick ? '0 : presc_r + 1'b1;
		remain_nxt = (step_tick && remain_r != '0) ? remain_r - 32'h0000_0001 : remain_r;
		count_nxt = count_r;
		ovf_nxt = ovf_r;
		bins_nxt = bins_r;
		index_nxt = index_r;
		emit = 1'b0;
		bin_start = 1'b0;
		if (state_r == S_COUNT && photon_rise) begin
			if (&count_r) ovf_nxt = 1'b1;
			else count_nxt = count_r + 31'h1;
		end
		if (!stop_req) begin
			unique case (state_r)
				S_IDLE: ;
				S_ARMED: begin
					if ((mode_r == `MODE_TRIG_TIMED || mode_r == `MODE_TRIG_UNTIMED) && trig_edge)
						bin_start = 1'b1;
					if (mode_r == `MODE_EXT_GATE && gate_in) bin_start = 1'b1;
				end
				S_COUNT: begin
					// edges inside a timed bin fall through here unused
					if (mode_r == `MODE_FREE_RUN && timer_done) begin
						emit = 1'b1;
						state_nxt = S_PAUSE;
						remain_nxt = pause_r;
					end
					if (mode_r == `MODE_TRIG_TIMED && timer_done) begin
						emit = 1'b1;
						state_nxt = S_ARMED;
					end
					if (mode_r == `MODE_TRIG_UNTIMED && trig_edge) begin
						emit = 1'b1;
						bin_start = 1'b1;
					end
					if (mode_r == `MODE_EXT_GATE && !gate_in) begin
						emit = 1'b1;
						state_nxt = S_ARMED;
					end
				end
				S_PAUSE: if (timer_done) bin_start = 1'b1;
				default: state_nxt = S_IDLE;
			endcase
		end else if (state_r == S_COUNT && mode_r == `MODE_MANUAL) begin
			emit = 1'b1;
		end
		if (bin_start) begin
			state_nxt = S_COUNT;
			count_nxt = '0;
			ovf_nxt = 1'b0;
			remain_nxt = bin_len_r;
			presc_nxt = '0;
		end
		if (emit) begin
			index_nxt = index_r + 32'h0000_0001;
			bins_nxt = bins_r + 14'h1;
			if (arr_state_r && bins_nxt == arr_len_r) begin
				stop_req = 1'b1;
			end
		end
		if (start_req) begin
			running_nxt = 1'b1;
			led_nxt = 1'b0;
			bins_nxt = '0;
			if (mode_r == `MODE_MANUAL || mode_r == `MODE_FREE_RUN) begin
				state_nxt = S_COUNT;
				count_nxt = '0;
				ovf_nxt = 1'b0;
				remain_nxt = bin_len_r;
				presc_nxt = '0;
			end else begin
				state_nxt = S_ARMED;
			end
		end
		if (stop_req) begin
			running_nxt = 1'b0;
			led_nxt = 1'b1;
			state_nxt = S_IDLE;
		end
		// new events are or-ed in after the clear, so an event in the clear cycle survives
		sticky_nxt = (clear_req ? 5'h00 : sticky_r)
			| {saturation_in, overtemp_in, emit && !fifo_ready, ovf_r};
		status_nxt = '0;
		status_nxt[`ST_RUN] = running_r;
		status_nxt[`ST_GATE] = state_r == S_COUNT;
		status_nxt[`ST_WAIT] = state_r == S_ARMED;
		status_nxt[`ST_OVF] = ovf_r;
		status_nxt[`ST_OVL] = !fifo_ready;
		status_nxt[`ST_TEMP] = overtemp_in;
		status_nxt[`ST_SAT +: 2] = saturation_in;
		status_nxt[`ST_ACC +: 5] = sticky_nxt;
		bias_nxt = !gating_r || (state_nxt == S_COUNT);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			mode_r <= `MODE_IDLE;
			gating_r <= 1'b0;
			bin_len_r <= `BIN_LEN_RST;
			pause_r <= `PAUSE_RST;
			edge_r <= 1'b1;
			arr_len_r <= `ARRAY_LEN_RST;
			arr_state_r <= 1'b0;
			fan_r <= `FAN_RST;
			led_r <= `LED_RST;
			dfu_r <= 2'h0;
			reenum_r <= 1'b0;
			running_r <= 1'b0;
			bias_r <= 1'b1;
			presc_r <= '0;
			remain_r <= '0;
			count_r <= '0;
			ovf_r <= 1'b0;
			bins_r <= '0;
			index_r <= '0;
			sticky_r <= '0;
			status_r <= '0;
			trig_prev_r <= 1'b0;
			photon_prev_r <= 1'b0;
			ans_valid_r <= 1'b0;
			ans_err_r <= 1'b0;
			ans_data_r <= '0;
		end else begin
			state_r <= state_nxt;
			mode_r <= mode_nxt;
			gating_r <= gating_nxt;
			bin_len_r <= bin_len_nxt;
			pause_r <= pause_nxt;
			edge_r <= edge_nxt;
			arr_len_r <= arr_len_nxt;
			arr_state_r <= arr_state_nxt;
			fan_r <= fan_nxt;
			led_r <= led_nxt;
			dfu_r <= dfu_nxt;
			reenum_r <= reenum_nxt;
			running_r <= running_nxt;
			bias_r <= bias_nxt;
			presc_r <= presc_nxt;
			remain_r <= remain_nxt;
			count_r <= count_nxt;
			ovf_r <= ovf_nxt;
			bins_r <= bins_nxt;
			index_r <= index_nxt;
			sticky_r <= sticky_nxt;
			status_r <= status_nxt;
			trig_prev_r <= trigger_in;
			photon_prev_r <= photon_in;
			ans_valid_r <= ans_valid_nxt;
			ans_err_r <= ans_err_nxt;
			ans_data_r <= ans_data_nxt;
		end
	end

	// a result is dropped when the fifo is full; the index gap tells the host
	result_fifo #(.WIDTH(80), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(emit),
		.in_ready(fifo_ready),
		.in_data({ovf_r, count_r, status_r, index_nxt}),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(fifo_out)
	);

	assign result_count = fifo_out[79:48];
	assign result_status = fifo_out[47:32];
	assign result_index = fifo_out[31:0];
	assign answer_valid = ans_valid_r;
	assign answer_error = ans_err_r;
	assign answer_data = ans_data_r;
	assign status_word = status_r;
	assign bias_enable = bias_r;
	assign fan_on = fan_r;
	assign led_on = led_r;
	assign dfu_state = dfu_r;
	assign usb_reenumerate = reenum_r;

	property p_mode_range;
		@(posedge mclk) disable iff (reset) mode_r <= 3'h5;
	endproperty
	a_mode_range: assert property (p_mode_range) else $error("mode out of range");

	property p_bias_gated;
		@(posedge mclk) disable iff (reset)
			(state_nxt == S_COUNT && state_r != S_COUNT) |=> bias_enable ##1 status_word[1];
	endproperty
	a_bias_gated: assert property (p_bias_gated) else $error("bias late at bin start");

	property p_arr_range;
		@(posedge mclk) disable iff (reset) arr_len_r >= 14'h1 && arr_len_r <= 14'h2710;
	endproperty
	a_arr_range: assert property (p_arr_range) else $error("array length out of range");

	property p_unused_zero;
		@(posedge mclk) disable iff (reset) status_word[9:8] == 2'b00 && !status_word[15];
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");

	property p_sticky_ovf;
		@(posedge mclk) disable iff (reset) ovf_r |=> status_word[10];
	endproperty
	a_sticky_ovf: assert property (p_sticky_ovf) else $error("sticky overflow missed");

	property p_clear;
		@(posedge mclk) disable iff (reset)
			clear_req && !ovf_r && !overtemp_in && saturation_in == 2'b00 && !emit
			|=> status_word[14:10] == 5'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("sticky bits not cleared");

	property p_start;
		@(posedge mclk) disable iff (reset)
			start_req && !stop_req |=> running_r && !led_on ##1 status_word[0];
	endproperty
	a_start: assert property (p_start) else $error("start did not run");

	property p_stop;
		@(posedge mclk) disable iff (reset)
			cmd_valid && cmd_write && cmd_sel == SEL_STOP |=> !running_r && led_on && state_r == S_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt");

	property p_timed_ignore;
		@(posedge mclk) disable iff (reset)
			state_r == S_COUNT && mode_r == 3'h3 && trig_edge && !timer_done
			&& !stop_req && !start_req
			|=> state_r == S_COUNT;
	endproperty
	a_timed_ignore: assert property (p_timed_ignore) else $error("trigger cut a timed bin");

	property p_reenum;
		@(posedge mclk) disable iff (reset)
			cmd_valid && cmd_write && cmd_sel == SEL_DFU && cmd_data[31:0] inside {32'h1, 32'h2}
			|=> usb_reenumerate ##1 !usb_reenumerate;
	endproperty
	a_reenum: assert property (p_reenum) else $error("no re-enumeration pulse");
endmodule : photon_counter_control

// ### verif/host_model.sv
// host side model: sends parsed commands and takes results from the result port
// assumes the bench calls send and take; detector inputs are driven by the bench
`timescale 1ns/100ps
module host_model
	import photon_counter_pkg::*;
(
	input wire logic mclk,
	output logic cmd_valid,
	output logic cmd_write,
	output cmd_sel_type cmd_sel,
	output logic [31:0] cmd_data,
	input wire logic answer_valid,
	input wire logic answer_error,
	input wire logic [31:0] answer_data,
	input wire logic result_valid,
	output logic result_ready,
	input wire logic [31:0] result_count,
	input wire logic [15:0] result_status,
	input wire logic [31:0] result_index
);
	logic fast_rate = 1'b0;
	logic [15:0] status_seen = 16'h0000;

	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_sel = SEL_MODE;
		cmd_data = 32'h0000_0000;
		result_ready = 1'b0;
	end

	task automatic send(input logic w, input cmd_sel_type s, input logic [31:0] d,
		output logic ok, output logic err, output logic [31:0] q);
		if (w && s == SEL_ARR_LEN && fast_rate && d > 32'h0000_03e8)
			d = 32'h0000_03e8;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_sel = s;
		cmd_data = d;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		// released data lines never keep the last value
		cmd_data = ~d;
		ok = answer_valid;
		err = answer_error;
		q = answer_data;
	endtask : send

	task automatic take(input int wait_cyc, output logic [31:0] c, output logic [31:0] i);
		int t;
		repeat (wait_cyc) @(posedge mclk);
		#1;
		result_ready = 1'b1;
		t = 0;
		// look between edges, so the values read are the ones the pop edge sees
		while (result_valid !== 1'b1 && t < 3000) begin
			@(posedge mclk);
			#1;
			t++;
		end
		// a result that never came reads as all ones, so the index check trips
		c = (result_valid === 1'b1) ? result_count : 32'hffff_ffff;
		i = (result_valid === 1'b1) ? result_index : 32'hffff_ffff;
		status_seen = result_status;
		@(posedge mclk);
		#1;
		result_ready = 1'b0;
	endtask : take
endmodule : host_model

// ### verif/tb_photon_counter_control.sv
// self-checking bench for the photon counter measurement control
// assumes the host model in host_model.sv; detector inputs driven here 1 ns after mclk
`timescale 1ns/100ps
`include "photon_counter_defs.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module tb_photon_counter_control;
	import photon_counter_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic photon = 1'b0;
	logic trig = 1'b0;
	logic gate = 1'b0;
	logic otemp = 1'b0;
	logic [1:0] sat = 2'h0;
	logic [11:0] mv = 12'h000;
	wire logic cv, cw, av, ae, rv, rr, bias, fan, led, reen;
	wire cmd_sel_type cs;
	wire logic [31:0] cd, ad, rc, ri;
	wire logic [15:0] st, rs;
	wire logic [1:0] dfu;
	int bad_count = 0, samples_checked = 0, cyc = 0, reen_cnt = 0, n = 0, t0 = 0;
	logic [31:0] seed = 32'h0000_97a4;
	logic [31:0] last [16];
	logic [31:0] q, c, i;
	logic [31:0] ex [3];
	logic ok, er;

	photon_counter_control #(.FIFO_DEPTH(8)) uut (.mclk(mclk), .reset(reset),
		.cmd_valid(cv), .cmd_write(cw), .cmd_sel(cs), .cmd_data(cd), .answer_valid(av),
		.answer_error(ae), .answer_data(ad), .photon_in(photon), .trigger_in(trig),
		.gate_in(gate), .overtemp_in(otemp), .saturation_in(sat), .sat_voltage_mv(mv),
		.result_valid(rv), .result_ready(rr), .result_count(rc), .result_status(rs),
		.result_index(ri), .status_word(st), .bias_enable(bias), .fan_on(fan),
		.led_on(led), .dfu_state(dfu), .usb_reenumerate(reen));
	host_model host (.mclk(mclk), .cmd_valid(cv), .cmd_write(cw), .cmd_sel(cs),
		.cmd_data(cd), .answer_valid(av), .answer_error(ae), .answer_data(ad),
		.result_valid(rv), .result_ready(rr), .result_count(rc), .result_status(rs),
		.result_index(ri));

	initial begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (reen === 1'b1)
			reen_cnt <= reen_cnt + 1;
	end

	function automatic logic [31:0] next_rand();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : next_rand
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	task automatic do_reset();
		tick(1);
		reset = 1'b1;
		trig = 1'b0;
		gate = 1'b0;
		otemp = 1'b0;
		sat = 2'h0;
		host.fast_rate = 1'b0;
		tick(10);
		reset = 1'b0;
		last = '{32'h0, 32'h0, `BIN_LEN_RST, `PAUSE_RST, 32'h1, 32'h1, 32'h0, 32'h0,
			32'(`FAN_RST), 32'(`LED_RST), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	endtask : do_reset
	task automatic cmd(input logic w, input cmd_sel_type s, input logic [31:0] d);
		host.send(w, s, d, ok, er, q);
		`CHK(ok, 1'b1);
	endtask : cmd
	task automatic wr_rd(input cmd_sel_type s, input logic [31:0] v, input logic bad);
		cmd(1'b1, s, v);
		`CHK(er, bad);
		if (!bad)
			last[s] = v;
		cmd(1'b0, s, 32'h0);
		`CHK(q, last[s]);
	endtask : wr_rd
	task automatic pulses(input int k);
		repeat (k) begin
			tick(1);
			photon = 1'b1;
			tick(1);
			photon = 1'b0;
		end
	endtask : pulses

	initial begin
		#(60000 * 8);
		bad_count++;
		end_of_test();
	end

	initial begin
		do_reset();
		`CHK({fan, led, bias, dfu, st}, {3'b111, 2'h0, 16'h0});
		for (int s = 0; s < 7; s++) begin
			cmd(1'b0, cmd_sel_type'(s), 32'h0);
			`CHK(q, last[s]);
		end
		cmd(1'b0, SEL_INDEX, 32'h0);
		`CHK(q, 32'h0);
		repeat (4) begin
			wr_rd(SEL_MODE, next_rand() % 6, 1'b0);
			wr_rd(SEL_GATING, next_rand() & 1, 1'b0);
			wr_rd(SEL_BIN_LEN, next_rand() & 32'h7fff_ffff | 1, 1'b0);
			wr_rd(SEL_PAUSE, next_rand() & 32'h7fff_ffff | 1, 1'b0);
			wr_rd(SEL_EDGE, next_rand() & 1, 1'b0);
			wr_rd(SEL_ARR_LEN, next_rand() % 10000 + 1, 1'b0);
			wr_rd(SEL_ARR_STATE, next_rand() & 1, 1'b0);
			wr_rd(SEL_FAN, next_rand() & 1, 1'b0);
			`CHK(fan, last[SEL_FAN][0]);
			wr_rd(SEL_LED, next_rand() & 1, 1'b0);
			`CHK(led, last[SEL_LED][0]);
		end
		wr_rd(SEL_BIN_LEN, 32'h7fff_ffff, 1'b0);
		wr_rd(SEL_BIN_LEN, 32'h0, 1'b1);
		wr_rd(SEL_PAUSE, 32'h8000_0000, 1'b1);
		wr_rd(SEL_MODE, 32'h6, 1'b1);
		wr_rd(SEL_EDGE, 32'h2, 1'b1);
		wr_rd(SEL_ARR_LEN, 32'd10000, 1'b0);
		wr_rd(SEL_ARR_LEN, 32'd10001, 1'b1);
		for (int v = 0; v < 4; v++) begin
			n = reen_cnt;
			wr_rd(SEL_DFU, v, v == 3);
			tick(2);
			`CHK(reen_cnt - n, v == 1 || v == 2);
			`CHK(dfu, last[SEL_DFU][1:0]);
		end
		mv = 12'(next_rand() % 3301);
		cmd(1'b0, SEL_SAT_VOLT, 32'h0);
		`CHK(q, mv);
		wr_rd(SEL_MODE, `MODE_IDLE, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		`CHK(er, 1'b1);
		$display("test settings done");

		do_reset();
		wr_rd(SEL_MODE, `MODE_MANUAL, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		tick(3);
		`CHK({st[`ST_RUN], led}, 2'b10);
		n = next_rand() % 20 + 1;
		pulses(n);
		tick(3);
		cmd(1'b1, SEL_STOP, 32'h0);
		host.take(0, c, i);
		`CHK(c, n);
		`CHK(i, 1);
		`CHK(host.status_seen, 16'h0003);
		tick(2);
		`CHK({st[`ST_RUN], led}, 2'b01);
		$display("test manual done");

		do_reset();
		host.fast_rate = 1'b1;
		wr_rd(SEL_MODE, `MODE_FREE_RUN, 1'b0);
		wr_rd(SEL_ARR_STATE, 1, 1'b0);
		wr_rd(SEL_ARR_LEN, 3, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		for (int k = 1; k < 4; k++) begin
			host.take(0, c, i);
			`CHK(i, k);
			`CHK(c, 0);
			if (k > 1)
				`CHK(cyc - t0 >= 248 && cyc - t0 <= 252, 1'b1);
			t0 = cyc;
		end
		tick(300);
		`CHK({rv, st[`ST_RUN], led, bias}, 4'b0011);
		$display("test free running done");

		do_reset();
		wr_rd(SEL_MODE, `MODE_TRIG_TIMED, 1'b0);
		wr_rd(SEL_EDGE, 0, 1'b0);
		wr_rd(SEL_BIN_LEN, 2, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		tick(3);
		`CHK(st[2:0], 3'b101);
		trig = 1'b1;
		tick(300);
		`CHK(rv, 1'b0);
		trig = 1'b0;
		t0 = cyc;
		tick(100);
		trig = 1'b1;
		tick(2);
		trig = 1'b0;
		tick(2);
		`CHK(st[2:0], 3'b011);
		host.take(0, c, i);
		`CHK(cyc - t0 >= 249 && cyc - t0 <= 256, 1'b1);
		tick(400);
		`CHK(rv, 1'b0);
		$display("test triggered timed done");

		do_reset();
		wr_rd(SEL_MODE, `MODE_TRIG_UNTIMED, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		for (int k = 0; k < 3; k++) begin
			trig = 1'b1;
			tick(2);
			trig = 1'b0;
			tick(4);
			ex[k] = next_rand() % 10 + 1;
			pulses(ex[k]);
			tick(4);
		end
		for (int k = 0; k < 2; k++) begin
			host.take(0, c, i);
			`CHK(c, ex[k]);
			`CHK(i, k + 1);
		end
		$display("test triggered untimed done");

		do_reset();
		wr_rd(SEL_GATING, 1, 1'b0);
		wr_rd(SEL_MODE, `MODE_EXT_GATE, 1'b0);
		cmd(1'b1, SEL_START, 32'h0);
		pulses(3);
		tick(2);
		`CHK(bias, 1'b0);
		gate = 1'b1;
		tick(4);
		`CHK({bias, st[`ST_GATE]}, 2'b11);
		n = next_rand() % 10 + 1;
		pulses(n);
		tick(3);
		gate = 1'b0;
		host.take(0, c, i);
		`CHK(c, n);
		`CHK(bias, 1'b0);
		$display("test gating done");

		do_reset();
		host.fast_rate = 1'b1;
		wr_rd(SEL_MODE, `MODE_FREE_RUN, 1'b0);
		otemp = 1'b1;
		sat = 2'h3;
		cmd(1'b1, SEL_START, 32'h0);
		// result port stalled: more bins than the fifo holds
		tick(2700);
		`CHK(st & 16'hfff8, 16'h78f0);
		cmd(1'b1, SEL_STOP, 32'h0);
		otemp = 1'b0;
		sat = 2'h0;
		for (int k = 1; k < 9; k++) begin
			host.take(next_rand() % 4, c, i);
			`CHK(i, k);
			if (k == 1)
				`CHK(host.status_seen, 16'h70e3);
		end
		tick(3);
		`CHK({rv, st}, {1'b0, 16'h7800});
		cmd(1'b1, SEL_CLEAR, 32'h0);
		tick(3);
		`CHK(st, 16'h0000);
		$display("test status and fifo done");
		end_of_test();
	end
endmodule : tb_photon_counter_control
